// >>> pkg/nvmem_host_pkg.sv
// Constants and types for the bytewide nonvolatile memory host controller.
// Assumes a 100 MHz clk; all pin timing is counted in cycles of it.
package nvmem_host_pkg;

	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int DEPTH  = 32768;

	localparam int CLK_PERIOD_NS = 10;

	// Chip select low window per cycle and least precharge time
	localparam int SEL_LOW_MIN_NS   = 70;
	localparam int SEL_LOW_MAX_NS   = 2000;
	localparam int PRECHARGE_MIN_NS = 70;
	// Access time to valid read data
	localparam int ACCESS_NS        = 70;
	// Write strobe low width, and write data set-up before strobe rise
	localparam int STROBE_MIN_NS    = 40;
	localparam int DATA_SETUP_NS    = 20;
	// Time after supply is good before the first access
	localparam int POWER_UP_NS      = 1000;

	localparam int SEL_LOW_CYC   = (SEL_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEL_MAX_CYC   = SEL_LOW_MAX_NS / CLK_PERIOD_NS;
	localparam int PRECHARGE_CYC = (PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC    = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC     = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWER_UP_CYC  = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int CNT_W = 8;

	localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	typedef enum {
		ST_POWERUP,
		ST_IDLE,
		ST_ACCESS,
		ST_PRECHARGE
	} host_state_type;

endpackage

// >>> rtl/cycle_timer.sv
// Loadable down counter used to time pin phases.
// Assumes loads and enables come from the same clk domain.
`timescale 1ns/1ps
module cycle_timer
	import nvmem_host_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clkEn,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] loadValue,
	output logic                  done,
	output logic [CNT_W-1:0]      count
);
	logic [CNT_W-1:0] count_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			count_r <= '0;
		end else if (clkEn) begin
			if (load) begin
				count_r <= loadValue;
			end else if (count_r != '0) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	assign count = count_r;
	assign done  = (count_r == '0);
endmodule

// >>> rtl/nvmem_host.sv
// Host controller driving a 32K x 8 bytewide nonvolatile memory through its pins.
// Assumes a 100 MHz clk, synchronous reset, and a user port on the same clock.
`timescale 1ns/1ps
module nvmem_host
	import nvmem_host_pkg::*;
(
	input  wire logic                              clk,
	input  wire logic                              reset,
	input  wire logic                              clkEn,
	input  wire logic                              supplyGood,
	input  wire logic                              reqValid,
	output logic                                   reqReady,
	input  wire logic                              reqWrite,
	input  wire logic [nvmem_host_pkg::ADDR_W-1:0] reqAddr,
	input  wire logic [nvmem_host_pkg::DATA_W-1:0] reqWrData,
	output logic                                   rdValid,
	output logic [nvmem_host_pkg::DATA_W-1:0]      rdData,
	output logic                                   chipSelect_n,
	output logic                                   outputDrive_n,
	output logic                                   writeStrobe_n,
	output logic [nvmem_host_pkg::ADDR_W-1:0]      memAddr,
	input  wire logic [nvmem_host_pkg::DATA_W-1:0] dataBusIn,
	output logic [nvmem_host_pkg::DATA_W-1:0]      dataBusOut,
	output logic                                   dataBusOe
);
	import nvmem_host_pkg::*;

	host_state_type   state_r;
	host_state_type   state_nxt;
	logic             isWrite_r;
	logic             supplyMeta_r;
	logic             supplySync_r;
	logic [DATA_W-1:0] busMeta_r;
	logic [DATA_W-1:0] busSync_r;
	logic             timerLoad;
	logic [CNT_W-1:0] timerValue;
	logic             timerDone;
	logic [CNT_W-1:0] timerCount;
	logic             chipSelect_r;
	logic             outputDrive_r;
	logic             writeStrobe_r;
	logic [ADDR_W-1:0] memAddr_r;
	logic [DATA_W-1:0] dataOut_r;
	logic             dataOe_r;
	logic [DATA_W-1:0] rdData_r;
	logic             rdValid_r;

	// Access phase length: select set-up cycle, min low time, two sync stages
	localparam logic [CNT_W-1:0] ACCESS_LOAD = CNT_W'(SEL_LOW_CYC + 3);
	localparam logic [CNT_W-1:0] PRE_LOAD    = CNT_W'(PRECHARGE_CYC);
	localparam logic [CNT_W-1:0] PWR_LOAD    = CNT_W'(POWER_UP_CYC);
	localparam logic [CNT_W-1:0] STROBE_REL  = 8'h01;

	cycle_timer u_timer (
		.clk       (clk),
		.reset     (reset),
		.clkEn     (clkEn),
		.load      (timerLoad),
		.loadValue (timerValue),
		.done      (timerDone),
		.count     (timerCount)
	);

	// Supply status and data bus come from outside the clock domain
	always_ff @(posedge clk) begin
		if (reset) begin
			supplyMeta_r <= 1'b0;
			supplySync_r <= 1'b0;
			busMeta_r    <= DATA_RESET;
			busSync_r    <= DATA_RESET;
		end else if (clkEn) begin
			supplyMeta_r <= supplyGood;
			supplySync_r <= supplyMeta_r;
			busMeta_r    <= dataBusIn;
			busSync_r    <= busMeta_r;
		end
	end

	assign reqReady = (state_r == ST_IDLE) && supplySync_r && clkEn;

	always_comb begin
		state_nxt  = state_r;
		timerLoad  = 1'b0;
		timerValue = '0;
		case (state_r)
			ST_POWERUP: begin
				if (!supplySync_r) begin
					timerLoad  = 1'b1;
					timerValue = PWR_LOAD;
				end else if (timerDone) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (!supplySync_r) begin
					state_nxt = ST_POWERUP;
				end else if (reqValid) begin
					state_nxt  = ST_ACCESS;
					timerLoad  = 1'b1;
					timerValue = ACCESS_LOAD;
				end
			end
			ST_ACCESS: begin
				if (timerDone) begin
					state_nxt  = ST_PRECHARGE;
					timerLoad  = 1'b1;
					timerValue = PRE_LOAD;
				end
			end
			ST_PRECHARGE: begin
				if (timerDone) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_POWERUP;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ST_POWERUP;
		end else if (clkEn) begin
			state_r <= state_nxt;
		end
	end

	// Request capture; address held steady through the whole access
	always_ff @(posedge clk) begin
		if (reset) begin
			isWrite_r <= 1'b0;
			memAddr_r <= ADDR_RESET;
			dataOut_r <= DATA_RESET;
		end else if (clkEn && reqReady && reqValid) begin
			isWrite_r <= reqWrite;
			memAddr_r <= reqAddr;
			dataOut_r <= reqWrData;
		end
	end

	// Pin control: chip select low only in the access phase
	always_ff @(posedge clk) begin
		if (reset) begin
			chipSelect_r  <= 1'b1;
			outputDrive_r <= 1'b1;
			writeStrobe_r <= 1'b1;
			dataOe_r      <= 1'b0;
		end else if (clkEn) begin
			if (state_nxt == ST_ACCESS) begin
				// Select falls a cycle after address, strobe and data settle
				chipSelect_r  <= (state_r != ST_ACCESS);
				// Strobe low before select falls: select-controlled write
				writeStrobe_r <= !(state_r == ST_ACCESS ? isWrite_r : reqWrite);
				// Strobe rises a cycle before select to keep data set-up
				if (state_r == ST_ACCESS && timerCount == STROBE_REL) begin
					writeStrobe_r <= 1'b1;
				end
				outputDrive_r <= (state_r == ST_ACCESS ? isWrite_r : reqWrite);
				dataOe_r      <= (state_r == ST_ACCESS ? isWrite_r : reqWrite);
			end else begin
				chipSelect_r  <= 1'b1;
				outputDrive_r <= 1'b1;
				writeStrobe_r <= 1'b1;
				dataOe_r      <= 1'b0;
			end
		end
	end

	// Read data taken after access time plus synchroniser delay
	always_ff @(posedge clk) begin
		if (reset) begin
			rdData_r  <= DATA_RESET;
			rdValid_r <= 1'b0;
		end else if (clkEn) begin
			rdValid_r <= 1'b0;
			if (state_r == ST_ACCESS && timerDone && !isWrite_r) begin
				rdData_r  <= busSync_r;
				rdValid_r <= 1'b1;
			end
		end
	end

	assign chipSelect_n  = chipSelect_r;
	assign outputDrive_n = outputDrive_r;
	assign writeStrobe_n = writeStrobe_r;
	assign memAddr       = memAddr_r;
	assign dataBusOut    = dataOut_r;
	assign dataBusOe     = dataOe_r;
	assign rdData        = rdData_r;
	assign rdValid       = rdValid_r;
endmodule

// >>> testbench/mem_model.sv
// Behavioural bytewide nonvolatile memory on the host pins.
// Assumes the bench feeds dataBusIn back to the host.
`timescale 1ns/1ps
module mem_model #(
	parameter int ACCESS_NS = 70
) (
	input  wire logic        chipSelect_n,
	input  wire logic        outputDrive_n,
	input  wire logic        writeStrobe_n,
	input  wire logic [14:0] memAddr,
	input  wire logic [7:0]  dataBusOut,
	input  wire logic        dataBusOe,
	output logic      [7:0]  dataBusIn
);
	logic [7:0]  mem [0:32767];
	logic [14:0] addr_r;
	logic        wr_r = 1'b0;
	logic        valid_r = 1'b0;
	logic        devOe;
	always @(negedge chipSelect_n) begin
		addr_r = memAddr;
		wr_r = !writeStrobe_n;
		valid_r = 1'b0;
		valid_r <= #(ACCESS_NS) 1'b1;
	end
	always @(negedge writeStrobe_n) if (!chipSelect_n) wr_r = 1'b1;
	always @(posedge writeStrobe_n or posedge chipSelect_n) begin
		if (wr_r) mem[addr_r] = dataBusIn;
		wr_r = 1'b0;
	end
	always @(posedge chipSelect_n) valid_r = 1'b0;
	assign devOe = !chipSelect_n && !outputDrive_n && valid_r && !wr_r;
	// Released bus shows the inverted byte so a stale value cannot pass
	assign dataBusIn = devOe ? mem[addr_r] : dataBusOe ? dataBusOut : ~mem[addr_r];
endmodule

// >>> testbench/nvmem_host_props.sv
// Pin timing checks for the memory host controller.
// Assumes one clk domain with synchronous active-high reset.
`timescale 1ns/1ps
module nvmem_host_props
	import nvmem_host_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              supplyGood,
	input wire logic [DATA_W-1:0] reqWrData,
	input wire logic              rdValid,
	input wire logic              chipSelect_n,
	input wire logic              outputDrive_n,
	input wire logic              writeStrobe_n,
	input wire logic [DATA_W-1:0] dataBusOut,
	input wire logic              dataBusOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_low;
		$fell(chipSelect_n) |-> !chipSelect_n[*8] ##1 !chipSelect_n[*2] ##1 chipSelect_n;
	endproperty
	a_low: assert property (p_low) else $error("select low time");
	property p_pre; $rose(chipSelect_n) |-> chipSelect_n[*7]; endproperty
	a_pre: assert property (p_pre) else $error("precharge short");
	property p_sup; $fell(chipSelect_n) |-> $past(supplyGood, 3); endproperty
	a_sup: assert property (p_sup) else $error("access without supply");
	property p_rd; $fell(chipSelect_n) && writeStrobe_n |-> !outputDrive_n ##[7:10] rdValid; endproperty
	a_rd: assert property (p_rd) else $error("read answer");
	property p_oe; !outputDrive_n |-> !dataBusOe; endproperty
	a_oe: assert property (p_oe) else $error("bus contention");
	property p_end; $rose(chipSelect_n) |-> writeStrobe_n; endproperty
	a_end: assert property (p_end) else $error("strobe after select");
	property p_wd; $fell(chipSelect_n) && !writeStrobe_n |-> dataBusOe && dataBusOut == $past(reqWrData); endproperty
	a_wd: assert property (p_wd) else $error("write data");
	property p_hold; $fell(writeStrobe_n) |=> ($stable(dataBusOut) && dataBusOe)[*8]; endproperty
	a_hold: assert property (p_hold) else $error("write data unstable");
	c_rd: cover property (rdValid);
	c_wr: cover property ($fell(writeStrobe_n));
	c_pre: cover property ($rose(chipSelect_n));
endmodule
bind nvmem_host nvmem_host_props nvmem_host_props_inst (.clk, .reset, .supplyGood, .reqWrData,
	.rdValid, .chipSelect_n, .outputDrive_n, .writeStrobe_n, .dataBusOut, .dataBusOe);

// >>> testbench/tb_top.sv
// Bench: host controller against a memory model and a reference array.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/1ps
module tb_top;
	import nvmem_host_pkg::*;
	logic              clk = 1'b0;
	logic              reset, clkEn, supplyGood, reqValid, reqReady, reqWrite, rdValid;
	logic              chipSelect_n, outputDrive_n, writeStrobe_n, dataBusOe;
	logic [ADDR_W-1:0] reqAddr, memAddr, a;
	logic [ADDR_W-1:0] addrs [$];
	logic [DATA_W-1:0] reqWrData, rdData, dataBusIn, dataBusOut, rdGot;
	logic [DATA_W-1:0] refMem [int];
	logic [31:0]       seed = 32'h6730;
	int                errCount = 0, checksDone = 0, nw, nr;
	always #5 clk = ~clk;
	nvmem_host nvmem_host_inst (.clk, .reset, .clkEn, .supplyGood, .reqValid, .reqReady,
		.reqWrite, .reqAddr, .reqWrData, .rdValid, .rdData, .chipSelect_n, .outputDrive_n,
		.writeStrobe_n, .memAddr, .dataBusIn, .dataBusOut, .dataBusOe);
	mem_model mem_model_inst (.chipSelect_n, .outputDrive_n, .writeStrobe_n, .memAddr,
		.dataBusOut, .dataBusOe, .dataBusIn);
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic quiet(input string what);
		@(negedge clk);
		check(what, {6'h00, reqReady, chipSelect_n}, 8'h01);
	endtask
	// One request at address a; waits for the answer and the return of ready
	task automatic access(input logic w, input logic [7:0] d, output int n);
		int k;
		k = 0;
		@(posedge clk);
		#1 {reqValid, reqWrite, reqAddr, reqWrData} = {1'b1, w, a, d};
		do begin
			@(negedge clk);
			k++;
		end while (reqReady !== 1'b1 && k < 400);
		@(posedge clk);
		#1 reqValid = 1'b0;
		n = 0;
		rdGot = ~refMem[a];
		do begin
			@(negedge clk);
			n++;
			if (rdValid === 1'b1) rdGot = rdData;
		end while (reqReady !== 1'b1 && n < 400);
		if (k >= 400 || n >= 400) errCount++;
	endtask
	initial begin
		{reset, clkEn, supplyGood, reqValid, reqWrite, reqAddr, reqWrData} = {3'b110, 25'h0};
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		repeat (20) quiet("noSupply");
		@(posedge clk);
		#1 supplyGood = 1'b1;
		for (int i = 0; i < 10; i++) begin
			seed = lfsrNext(seed);
			a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7fff : seed[14:0];
			refMem[a] = seed[22:15];
			access(1'b1, seed[22:15], nw);
			addrs.push_back(a);
			access(1'b0, 8'h00, nr);
			check("readAfterWrite", rdGot, refMem[a]);
			check("cycleLength", 8'(nr), 8'(nw));
		end
		@(posedge clk);
		#1 clkEn = 1'b0;
		repeat (4) quiet("frozen");
		@(posedge clk);
		#1 clkEn = 1'b1;
		@(posedge clk);
		#1 supplyGood = 1'b0;
		repeat (3) @(posedge clk);
		repeat (4) quiet("supplyDrop");
		@(posedge clk);
		#1 supplyGood = 1'b1;
		while (addrs.size() > 0) begin
			a = addrs.pop_back();
			access(1'b0, 8'h00, nr);
			check("readBack", rdGot, refMem[a]);
		end
		conclude();
	end
	// Run needs about 9 us; the watchdog allows far more
	initial begin
		#100000;
		errCount++;
		conclude();
	end
endmodule
